// [design/eag_operand.sv]
`timescale 1ns/1ps
// one operand channel: address and write-back for one mode
module eag_operand #(
   parameter int DW = 16
) (
   // operand selection
   input  wire logic [3:0]    mode,
   input  wire logic [12:0]   file_addr,
   input  wire logic [DW-1:0] base_val,
   input  wire logic [DW-1:0] index_val,
   input  wire logic [DW-1:0] lit_ofs,
   input  wire logic [DW-1:0] step,
   input  wire logic [DW-1:0] lit_val,
   // results
   output logic [DW-1:0]      ea,
   output logic [DW-1:0]      operand,
   output logic               mem_access,
   output logic               wb_en,
   output logic [DW-1:0]      wb_val
);
   // wrapping add at working width, no flag
   function automatic logic [DW-1:0] wadd(input logic [DW-1:0] a,
                                          input logic [DW-1:0] b);
      wadd = DW'(a + b);
   endfunction

   wire logic [DW-1:0] mod_val = wadd(base_val, step);

   // address per mode
   always_comb begin
      ea = '0;
      operand = '0;
      mem_access = 1'b0;
      wb_en = 1'b0;
      wb_val = mod_val;
      case (mode)
         // RL1 - file address verbatim
         eag_pkg::EAG_AM_FILE: begin
            ea = DW'(file_addr);
            mem_access = 1'b1;
         end
         // RL2 - register value itself
         eag_pkg::EAG_AM_REG: operand = base_val;
         // RL3 - pointer is address
         eag_pkg::EAG_AM_IND: begin
            ea = base_val;
            mem_access = 1'b1;
         end
         // RL4 - old value, then modify
         eag_pkg::EAG_AM_POST: begin
            ea = base_val;
            mem_access = 1'b1;
            wb_en = 1'b1;
         end
         // RL5 - modified value used twice
         eag_pkg::EAG_AM_PRE: begin
            ea = mod_val;
            mem_access = 1'b1;
            wb_en = 1'b1;
         end
         // RL6 RL16 - pointer plus index
         eag_pkg::EAG_AM_INDEX: begin
            ea = wadd(base_val, index_val);
            mem_access = 1'b1;
         end
         // RL7 RL16 - pointer plus literal
         eag_pkg::EAG_AM_LOFS: begin
            ea = wadd(base_val, lit_ofs);
            mem_access = 1'b1;
         end
         eag_pkg::EAG_AM_LIT8,
         eag_pkg::EAG_AM_LIT16: operand = lit_val;
         default: ;
      endcase
   end
endmodule // eag_operand

// [design/eag_top.sv]
`timescale 1ns/1ps
// What this block does
// RL1 - file-direct address comes straight from instruction field
// RL2 - register-direct operand is the working register value
// RL3 - indirect address equals base pointer contents
// RL4 - post-modify: access at old pointer, then write back modified
// RL5 - pre-modify: modified pointer is address and written back
// RL6 - indexed address is base pointer plus offset index register
// RL7 - literal-offset address is base pointer plus literal
// RL8 - data transfers also accept indexed mode
// RL9 - transfer source and destination share one 4-bit index selector
// RL10 - transfers allow six pointer modes plus 8/16-bit literals
// RL11 - each instruction limited to its own mode subset
// RL12 - relative jump uses 16-bit signed literal
// RL13 - interrupt hold count is 14-bit unsigned literal
// RL14 - accumulator ops have operands implied by opcode
// RL15 - idle op yields no address and no register access
// RL16 - sums wrap at 16 bits, no flag
module eag_top #(
   parameter int DW = eag_pkg::DATA_W
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              resetn,
   // decoded instruction
   input  wire logic              valid,
   input  wire logic [2:0]        op_class,
   input  wire logic [3:0]        src_mode,
   input  wire logic [3:0]        dst_mode,
   input  wire logic [3:0]        src_base_sel,
   input  wire logic [3:0]        dst_base_sel,
   input  wire logic [3:0]        offset_sel,
   input  wire logic [12:0]       file_addr,
   input  wire logic [9:0]        lit_ofs,
   input  wire logic              dec_step,
   input  wire logic [1:0]        step_size,
   input  wire logic [15:0]       literal,
   // register file read data
   input  wire logic [DW-1:0]     src_base_reg,
   input  wire logic [DW-1:0]     dst_base_reg,
   input  wire logic [DW-1:0]     offset_index_reg,
   // operand results
   output logic                   out_valid,
   output logic                   mode_error,
   output logic [DW-1:0]          src_ea,
   output logic [DW-1:0]          src_operand,
   output logic                   src_mem_rd,
   output logic [DW-1:0]          dst_ea,
   output logic                   dst_mem_wr,
   output logic                   reg_rd_en,
   output logic [3:0]             index_sel_out,
   // pointer write-back
   output logic                   src_wb_en,
   output logic [3:0]             src_wb_sel,
   output logic [DW-1:0]          src_wb_val,
   output logic                   dst_wb_en,
   output logic [3:0]             dst_wb_sel,
   output logic [DW-1:0]          dst_wb_val,
   // literal fields and implied-accumulator flag
   output logic [DW-1:0]          jump_offset,
   output logic [13:0]            hold_count,
   output logic                   accum_implied
);
   // ******************************************************
   // elaboration checks
   // ******************************************************
   if (DW != 16) begin : g_bad_width
      $error("eag_top supports only a 16-bit working width");
   end

   // ******************************************************
   // mode legality
   // ******************************************************
   function automatic logic mode_ok(input logic [15:0] mask,
                                    input logic [3:0] m);
      mode_ok = mask[m];
   endfunction

   wire logic is_xfer  = op_class == eag_pkg::EAG_OP_XFER;
   wire logic is_alu   = op_class == eag_pkg::EAG_OP_ALU;
   wire logic is_accum = op_class == eag_pkg::EAG_OP_ACCUM;
   wire logic is_jump  = op_class == eag_pkg::EAG_OP_JUMP;
   wire logic is_hold  = op_class == eag_pkg::EAG_OP_HOLD;
   wire logic is_idle  = op_class == eag_pkg::EAG_OP_IDLE;

   // RL8 RL10 RL11 - per-class subset
   wire logic [15:0] allowed =
      is_xfer  ? eag_pkg::XFER_MODES  :
      is_alu   ? eag_pkg::ALU_MODES   :
      is_accum ? eag_pkg::ACCUM_MODES : eag_pkg::NONE_MODES;
   wire logic legal = mode_ok(allowed, src_mode) &&
                      mode_ok(allowed, dst_mode) &&
                      (op_class <= 3'(eag_pkg::EAG_OP_ACCUM));
   wire logic act = valid && legal;

   // RL14 RL15 - operandless classes force no mode
   wire logic       addr_cls = is_xfer || is_alu;
   wire logic [3:0] eff_src  = addr_cls ? src_mode : 4'h0;
   wire logic [3:0] eff_dst  = addr_cls && !mode_ok(16'h0300, dst_mode)
                               ? dst_mode : 4'h0;

   // step of 1, 2, 4 or 8, signed by direction
   wire logic [DW-1:0] mag  = DW'(16'h0001 << step_size);
   wire logic [DW-1:0] step = dec_step ? DW'(-mag) : mag;
   wire logic [DW-1:0] lofs = DW'({{6{lit_ofs[9]}}, lit_ofs});
   wire logic [DW-1:0] lit_v = src_mode == eag_pkg::EAG_AM_LIT8
                               ? DW'(literal[7:0]) : literal;

   wire logic [DW-1:0] s_ea, s_opnd, s_wbv, d_ea, d_wbv;
   wire logic          s_mem, s_wb, d_mem, d_wb;

   // ******************************************************
   // operand channels
   // ******************************************************
   // RL9 - one index register feeds both
   eag_operand #(.DW(DW)) u_src (
      .mode       (eff_src),
      .file_addr  (file_addr),
      .base_val   (src_base_reg),
      .index_val  (offset_index_reg),
      .lit_ofs    (lofs),
      .step       (step),
      .lit_val    (lit_v),
      .ea         (s_ea),
      .operand    (s_opnd),
      .mem_access (s_mem),
      .wb_en      (s_wb),
      .wb_val     (s_wbv)
   );
   eag_operand #(.DW(DW)) u_dst (
      .mode       (eff_dst),
      .file_addr  (file_addr),
      .base_val   (dst_base_reg),
      .index_val  (offset_index_reg),
      .lit_ofs    (lofs),
      .step       (step),
      .lit_val    (literal),
      .ea         (d_ea),
      .operand    (),
      .mem_access (d_mem),
      .wb_en      (d_wb),
      .wb_val     (d_wbv)
   );

   // register reads only when a pointer or register mode is used
   wire logic uses_reg = !mode_ok(16'h0303, eff_src) ||
                         !mode_ok(16'h0303, eff_dst);

   // ******************************************************
   // output registers, one cycle after the request
   // ******************************************************
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         out_valid     <= 1'b0;
         mode_error    <= 1'b0;
         src_ea        <= eag_pkg::RST_WORD;
         src_operand   <= eag_pkg::RST_WORD;
         src_mem_rd    <= 1'b0;
         dst_ea        <= eag_pkg::RST_WORD;
         dst_mem_wr    <= 1'b0;
         reg_rd_en     <= 1'b0;
         index_sel_out <= 4'h0;
         src_wb_en     <= 1'b0;
         src_wb_sel    <= 4'h0;
         src_wb_val    <= eag_pkg::RST_WORD;
         dst_wb_en     <= 1'b0;
         dst_wb_sel    <= 4'h0;
         dst_wb_val    <= eag_pkg::RST_WORD;
         jump_offset   <= eag_pkg::RST_WORD;
         hold_count    <= 14'h0000;
         accum_implied <= 1'b0;
      end else begin
         out_valid     <= act;
         mode_error    <= valid && !legal;
         src_ea        <= s_ea;
         src_operand   <= s_opnd;
         src_mem_rd    <= act && s_mem;
         dst_ea        <= d_ea;
         dst_mem_wr    <= act && d_mem;
         // RL15 - idle gives no register access
         reg_rd_en     <= act && uses_reg && !is_idle;
         index_sel_out <= offset_sel;
         src_wb_en     <= act && s_wb;
         src_wb_sel    <= src_base_sel;
         src_wb_val    <= s_wbv;
         dst_wb_en     <= act && d_wb;
         dst_wb_sel    <= dst_base_sel;
         dst_wb_val    <= d_wbv;
         // RL12 - signed jump literal
         jump_offset   <= is_jump ? literal : eag_pkg::RST_WORD;
         // RL13 - unsigned 14-bit count
         hold_count    <= is_hold ? literal[13:0] : 14'h0000;
         // RL14 - accumulator implied
         accum_implied <= act && is_accum;
      end
   end

   // ******************************************************
   // checks
   // ******************************************************
   a_idle_quiet: assert property (@(posedge clock) disable iff (!resetn)
      valid && is_idle |=> !src_mem_rd && !dst_mem_wr && !reg_rd_en) // RL15
      else $error("idle op produced an access");
   a_post_addr: assert property (@(posedge clock) disable iff (!resetn)
      act && eff_src == eag_pkg::EAG_AM_POST |=>
      src_ea == $past(src_base_reg) &&
      src_wb_val == 16'($past(src_base_reg) + $past(step))) // RL4
      else $error("post-modify address wrong");
   a_pre_addr: assert property (@(posedge clock) disable iff (!resetn)
      act && eff_src == eag_pkg::EAG_AM_PRE |=>
      src_ea == 16'($past(src_base_reg) + $past(step)) &&
      src_ea == src_wb_val && src_wb_en) // RL5
      else $error("pre-modify address differs from write-back");
   a_shared_index: assert property (@(posedge clock) disable iff (!resetn)
      act && is_xfer |=> index_sel_out == $past(offset_sel)) // RL9
      else $error("shared index selector not passed on");
   a_index_sum: assert property (@(posedge clock) disable iff (!resetn)
      act && eff_src == eag_pkg::EAG_AM_INDEX |=>
      src_ea == 16'($past(src_base_reg) + $past(offset_index_reg))) // RL6
      else $error("indexed address wrong");
   a_file_addr: assert property (@(posedge clock) disable iff (!resetn)
      act && eff_src == eag_pkg::EAG_AM_FILE |=>
      src_ea == 16'($past(file_addr)) && src_mem_rd) // RL1
      else $error("file address not verbatim");
   a_ind_addr: assert property (@(posedge clock) disable iff (!resetn)
      act && eff_src == eag_pkg::EAG_AM_IND |=>
      src_ea == $past(src_base_reg) && !src_wb_en) // RL3
      else $error("indirect address wrong");
   a_alu_index: assert property (@(posedge clock) disable iff (!resetn)
      valid && is_alu && src_mode == eag_pkg::EAG_AM_INDEX |=>
      mode_error && !out_valid) // RL11
      else $error("indexed accepted for ordinary op");
   a_hold_cnt: assert property (@(posedge clock) disable iff (!resetn)
      is_hold |=> hold_count == $past(literal[13:0])) // RL13
      else $error("hold count wrong");
   a_jump_lit: assert property (@(posedge clock) disable iff (!resetn)
      is_jump |=> jump_offset == $past(literal)) // RL12
      else $error("jump literal wrong");
   c_xfer_index: cover property (@(posedge clock)
      act && is_xfer && src_mode == eag_pkg::EAG_AM_INDEX);
   c_post_mod: cover property (@(posedge clock)
      act && src_mode == eag_pkg::EAG_AM_POST);
   c_bad_mode: cover property (@(posedge clock) valid && !legal);
endmodule // eag_top

// [shared/eag_pkg.sv]
package eag_pkg;
   // ******************************************************
   // widths
   // ******************************************************
   localparam int DATA_W      = 16;
   localparam int SEL_W       = 4;
   localparam int FILE_ADDR_W = 13;
   localparam int LIT8_W      = 8;
   localparam int LIT16_W     = 16;
   localparam int JUMP_LIT_W  = 16;
   localparam int HOLD_LIT_W  = 14;
   localparam int OFS_LIT_W   = 10;
   localparam int REG_COUNT   = 16;

   // ******************************************************
   // operation classes
   // ******************************************************
   typedef enum logic [2:0] {
      EAG_OP_IDLE  = 3'b000,   // idle_op, no operands
      EAG_OP_ALU   = 3'b001,   // ordinary instruction
      EAG_OP_XFER  = 3'b010,   // data_transfer_op
      EAG_OP_JUMP  = 3'b011,   // jump_relative_op
      EAG_OP_HOLD  = 3'b100,   // interrupt_hold_op
      EAG_OP_ACCUM = 3'b101    // implied accumulator operand
   } eag_op_t;

   // ******************************************************
   // addressing modes
   // ******************************************************
   typedef enum logic [3:0] {
      EAG_AM_NONE  = 4'h0,
      EAG_AM_FILE  = 4'h1,
      EAG_AM_REG   = 4'h2,
      EAG_AM_IND   = 4'h3,
      EAG_AM_POST  = 4'h4,
      EAG_AM_PRE   = 4'h5,
      EAG_AM_INDEX = 4'h6,
      EAG_AM_LOFS  = 4'h7,
      EAG_AM_LIT8  = 4'h8,
      EAG_AM_LIT16 = 4'h9
   } eag_mode_t;

   // ******************************************************
   // permitted mode masks, bit n set = mode n allowed
   // ******************************************************
   localparam logic [15:0] ALU_MODES   = 16'h00BE;
   localparam logic [15:0] XFER_MODES  = 16'h03FC;
   localparam logic [15:0] ACCUM_MODES = 16'h0001;
   localparam logic [15:0] NONE_MODES  = 16'h0001;

   // ******************************************************
   // reset values
   // ******************************************************
   localparam logic [15:0] RST_WORD = 16'h0000;
endpackage

// [verification/eag_regfile_model.sv]
`timescale 1ns/1ps
// working register file seen by the block: same-cycle reads, write-back
module eag_regfile_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // read selectors
   input  wire logic [3:0]  src_base_sel,
   input  wire logic [3:0]  dst_base_sel,
   input  wire logic [3:0]  offset_sel,
   // pointer write-back
   input  wire logic        src_wb_en,
   input  wire logic [3:0]  src_wb_sel,
   input  wire logic [15:0] src_wb_val,
   input  wire logic        dst_wb_en,
   input  wire logic [3:0]  dst_wb_sel,
   input  wire logic [15:0] dst_wb_val,
   // read data
   output logic [15:0]      src_base_reg,
   output logic [15:0]      dst_base_reg,
   output logic [15:0]      offset_index_reg
);
   logic [15:0] regs [16];

   // read ports, combinational like the core's file
   assign src_base_reg     = regs[src_base_sel];
   assign dst_base_reg     = regs[dst_base_sel];
   assign offset_index_reg = regs[offset_sel];

   // reset fills nnnn per register, so r15 holds all ones for wrap tests
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 16; i++)
            regs[i] <= {4{4'(i)}};
      end else begin
         if (src_wb_en)
            regs[src_wb_sel] <= src_wb_val;
         if (dst_wb_en)
            regs[dst_wb_sel] <= dst_wb_val;
      end
   end
endmodule // eag_regfile_model

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
   // ************************************************
   // signals
   // ************************************************
   logic        clock, resetn, valid, dec_step;
   logic [2:0]  op_class;
   logic [3:0]  src_mode, dst_mode, src_base_sel, dst_base_sel, offset_sel;
   logic [12:0] file_addr;
   logic [9:0]  lit_ofs;
   logic [1:0]  step_size;
   logic [15:0] literal, src_base_reg, dst_base_reg, offset_index_reg;
   logic [15:0] src_ea, src_operand, dst_ea, src_wb_val, dst_wb_val;
   logic [15:0] jump_offset;
   logic [13:0] hold_count;
   logic [3:0]  index_sel_out, src_wb_sel, dst_wb_sel;
   logic        out_valid, mode_error, src_mem_rd, dst_mem_wr, reg_rd_en;
   logic        src_wb_en, dst_wb_en, accum_implied;
   int          miscompares, checks_done;
   logic [15:0] mr [16];   // bench copy of the register file

   eag_top u_eag_top (.clock, .resetn, .valid, .op_class, .src_mode,
      .dst_mode, .src_base_sel, .dst_base_sel, .offset_sel, .file_addr,
      .lit_ofs, .dec_step, .step_size, .literal, .src_base_reg,
      .dst_base_reg, .offset_index_reg, .out_valid, .mode_error, .src_ea,
      .src_operand, .src_mem_rd, .dst_ea, .dst_mem_wr, .reg_rd_en,
      .index_sel_out, .src_wb_en, .src_wb_sel, .src_wb_val, .dst_wb_en,
      .dst_wb_sel, .dst_wb_val, .jump_offset, .hold_count, .accum_implied);
   eag_regfile_model u_eag_regfile_model (.clock, .resetn, .src_base_sel,
      .dst_base_sel, .offset_sel, .src_wb_en, .src_wb_sel, .src_wb_val,
      .dst_wb_en, .dst_wb_sel, .dst_wb_val, .src_base_reg, .dst_base_reg,
      .offset_index_reg);

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // ************************************************
   // helpers
   // ************************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // request goes out at a falling edge; caller may add fields before take
   task automatic req(input logic [2:0] op, input logic [3:0] sm, sb, dm, db);
      @(negedge clock);
      op_class = op;
      src_mode = sm;
      src_base_sel = sb;
      dst_mode = dm;
      dst_base_sel = db;
      valid = 1'b1;
   endtask

   // the idle cycle after lets the model absorb any write-back
   task automatic take;
      @(posedge clock);
      @(negedge clock);
      valid = 1'b0;
   endtask

   function automatic logic [15:0] moved(input logic [15:0] b);
      logic [15:0] st;
      st = 16'h0001 << step_size;
      return dec_step ? b - st : b + st;
   endfunction

   task automatic end_sim;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ************************************************
   // tests
   // ************************************************
   task automatic t_ordinary;
      logic [3:0]  m;
      logic [15:0] b, e;
      for (int k = 1; k < 8; k++) begin
         m = 4'(k);
         if (k != 6) begin
            req(eag_pkg::EAG_OP_ALU, m, m, eag_pkg::EAG_AM_REG, 4'h1);
            dec_step = m[0];
            step_size = m[1:0];
            file_addr = 13'h1ABC;
            lit_ofs = 10'h3F0;
            b = mr[m];
            case (m)
               eag_pkg::EAG_AM_FILE: e = {3'h0, file_addr};
               eag_pkg::EAG_AM_PRE:  e = moved(b);
               eag_pkg::EAG_AM_LOFS: e = b + {{6{lit_ofs[9]}}, lit_ofs};
               default:              e = b;
            endcase
            take;
            chk(out_valid, 1'b1);
            if (m == eag_pkg::EAG_AM_REG)
               chk(src_operand, b);
            else
               chk(src_ea, e);
            chk(src_mem_rd, m != eag_pkg::EAG_AM_REG);
            chk(dst_mem_wr, 1'b0);
            chk(reg_rd_en, 1'b1);
            chk(src_wb_en, m == 4'h4 || m == 4'h5);
            if (m == 4'h4 || m == 4'h5) begin
               chk(src_wb_val, moved(b));
               chk(src_wb_sel, m);
               mr[m] = moved(b);
            end
         end
      end
      $display("ordinary modes done");
   endtask

   task automatic t_transfer;
      // indexed source off all-ones wraps, shared selector feeds it
      req(eag_pkg::EAG_OP_XFER, eag_pkg::EAG_AM_INDEX, 4'hF,
          eag_pkg::EAG_AM_POST, 4'hE);
      offset_sel = 4'h2;
      dec_step = 1'b0;
      step_size = 2'h3;
      take;
      chk(src_ea, 16'h2221);
      chk(index_sel_out, 4'h2);
      chk(dst_ea, 16'hEEEE);
      chk(dst_mem_wr, 1'b1);
      chk(dst_wb_val, 16'hEEF6);
      chk(dst_wb_sel, 4'hE);
      chk(dst_wb_en, 1'b1);
      chk(out_valid, 1'b1);
      mr[14] = 16'hEEF6;
      // roles swapped: post-decrement source, indexed destination
      req(eag_pkg::EAG_OP_XFER, eag_pkg::EAG_AM_POST, 4'hD,
          eag_pkg::EAG_AM_INDEX, 4'hC);
      offset_sel = 4'h3;
      dec_step = 1'b1;
      step_size = 2'h0;
      take;
      chk(src_ea, 16'hDDDD);
      chk(src_wb_val, 16'hDDDC);
      chk(dst_ea, 16'hFFFF);
      mr[13] = 16'hDDDC;
      // pre-decrement of zero wraps round
      req(eag_pkg::EAG_OP_XFER, eag_pkg::EAG_AM_PRE, 4'h0,
          eag_pkg::EAG_AM_REG, 4'h1);
      take;
      chk(src_ea, 16'hFFFF);
      chk(src_wb_val, 16'hFFFF);
      mr[0] = 16'hFFFF;
      // literal offset source, pre-increment by four at destination
      req(eag_pkg::EAG_OP_XFER, eag_pkg::EAG_AM_LOFS, 4'h6,
          eag_pkg::EAG_AM_PRE, 4'hB);
      lit_ofs = 10'h010;
      dec_step = 1'b0;
      step_size = 2'h2;
      take;
      chk(src_ea, 16'h6676);
      chk(src_mem_rd, 1'b1);
      chk(dst_ea, 16'hBBBF);
      chk(dst_wb_en, 1'b1);
      chk(dst_wb_val, 16'hBBBF);
      chk(dst_wb_sel, 4'hB);
      mr[11] = 16'hBBBF;
      // both immediate widths
      req(eag_pkg::EAG_OP_XFER, eag_pkg::EAG_AM_LIT8, 4'h0,
          eag_pkg::EAG_AM_REG, 4'h1);
      literal = 16'hA55A;
      take;
      chk(src_operand, 16'h005A);
      chk(src_mem_rd, 1'b0);
      req(eag_pkg::EAG_OP_XFER, eag_pkg::EAG_AM_LIT16, 4'h0,
          eag_pkg::EAG_AM_REG, 4'h1);
      take;
      chk(src_operand, 16'hA55A);
      $display("transfer modes done");
   endtask

   task automatic t_refuse;
      logic [2:0] op [5];
      logic [3:0] md [5];
      op = '{eag_pkg::EAG_OP_ALU, eag_pkg::EAG_OP_ALU, eag_pkg::EAG_OP_XFER,
             eag_pkg::EAG_OP_ACCUM, 3'h6};
      md = '{eag_pkg::EAG_AM_INDEX, eag_pkg::EAG_AM_LIT8,
             eag_pkg::EAG_AM_FILE, eag_pkg::EAG_AM_FILE, eag_pkg::EAG_AM_NONE};
      for (int k = 0; k < 5; k++) begin
         req(op[k], md[k], 4'h4, eag_pkg::EAG_AM_REG, 4'h1);
         take;
         chk(mode_error, 1'b1);
         chk(out_valid, 1'b0);
         chk(src_mem_rd | src_wb_en, 1'b0);
      end
      $display("refusals done");
   endtask

   task automatic t_literals;
      req(eag_pkg::EAG_OP_JUMP, 4'h0, 4'h0, 4'h0, 4'h0);
      literal = 16'h8001;
      take;
      chk(jump_offset, 16'h8001);
      req(eag_pkg::EAG_OP_HOLD, 4'h0, 4'h0, 4'h0, 4'h0);
      literal = 16'hFFFF;
      take;
      chk(hold_count, 14'h3FFF);
      req(eag_pkg::EAG_OP_ACCUM, 4'h0, 4'h0, 4'h0, 4'h0);
      take;
      chk(accum_implied, 1'b1);
      chk(src_mem_rd | dst_mem_wr | reg_rd_en, 1'b0);
      req(eag_pkg::EAG_OP_IDLE, 4'h0, 4'h0, 4'h0, 4'h0);
      take;
      chk(mode_error, 1'b0);
      chk(src_mem_rd | dst_mem_wr | reg_rd_en, 1'b0);
      chk(src_wb_en | dst_wb_en, 1'b0);
      $display("literal and implied ops done");
   endtask

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      {valid, resetn, dec_step, op_class, src_mode, dst_mode} = '0;
      {src_base_sel, dst_base_sel, offset_sel, file_addr} = '0;
      {lit_ofs, step_size, literal} = '0;
      miscompares = 0;
      checks_done = 0;
      for (int i = 0; i < 16; i++)
         mr[i] = {4{4'(i)}};
      repeat (6) @(posedge clock);
      @(negedge clock);
      // outputs held quiet while in reset
      chk(out_valid | mode_error | accum_implied, 1'b0);
      chk(src_mem_rd | dst_mem_wr | reg_rd_en, 1'b0);
      chk(src_wb_en | dst_wb_en, 1'b0);
      chk(src_ea | dst_ea | jump_offset, 16'h0000);
      resetn = 1'b1;
      t_ordinary;
      t_transfer;
      t_refuse;
      t_literals;
      end_sim;
   end

   // watchdog: the tests need well under 200 cycles
   initial begin
      #20000;
      miscompares++;
      $display("[FAIL] t=%0t watchdog expired", $time);
      end_sim;
   end
endmodule // tb
